// >>> hdl/pcpa_pkg.sv
// constants for the priority crossbar pin assigner
package pcpa_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int unsigned PCPA_NPIN = 24;
  localparam int unsigned PCPA_NFN = 26;
  localparam int unsigned PCPA_NFIX = 6;
  localparam int unsigned PCPA_NFLT = 20;
  localparam int unsigned PCPA_AW = 4;
  localparam int unsigned PCPA_DW = 8;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [3:0] PCPA_OFS_SEL_A = 4'h0;
  localparam logic [3:0] PCPA_OFS_SEL_B = 4'h1;
  localparam logic [3:0] PCPA_OFS_SEL_C = 4'h2;
  localparam logic [3:0] PCPA_OFS_SKIP0 = 4'h3;
  localparam logic [3:0] PCPA_OFS_MODE0 = 4'h6;
  localparam logic [3:0] PCPA_OFS_CLAIM0 = 4'h9;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and writable masks
  localparam logic [7:0] PCPA_RST_SEL = 8'h00;
  localparam logic [7:0] PCPA_RST_SKIP = 8'h00;
  localparam logic [7:0] PCPA_RST_MODE = 8'h00;
  localparam logic [7:0] PCPA_MASK_SEL_B = 8'h7f;
  localparam logic [7:0] PCPA_MASK_SEL_C = 8'h40;

  ////////////////////////////////////////////////////////////////////////////
  // field positions, selection a
  localparam int unsigned PCPA_A_SERIAL = 0;
  localparam int unsigned PCPA_A_FIRST_SPI_PORT = 1;
  localparam int unsigned PCPA_A_TWB = 2;
  localparam int unsigned PCPA_A_SYSCLK = 3;
  localparam int unsigned PCPA_A_CMP0 = 4;
  localparam int unsigned PCPA_A_CMP0A = 5;
  localparam int unsigned PCPA_A_CMP1 = 6;
  localparam int unsigned PCPA_A_CMP1A = 7;
  // selection b
  localparam int unsigned PCPA_B_CHAN_LSB = 0;
  localparam int unsigned PCPA_B_EXTCNT = 3;
  localparam int unsigned PCPA_B_TMR0 = 4;
  localparam int unsigned PCPA_B_TMR1 = 5;
  localparam int unsigned PCPA_B_SECOND_SPI_PORT = 6;
  localparam logic [2:0] PCPA_CHAN_RSVD = 3'h7;
  // selection c
  localparam int unsigned PCPA_C_XBE = 6;
  // slave select mode code for 3-wire operation
  localparam logic [1:0] PCPA_NSS_3WIRE = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // fixed pins and candidate range
  localparam int unsigned PCPA_PIN_TX = 4;
  localparam int unsigned PCPA_PIN_RX = 5;
  localparam int unsigned PCPA_PIN_S1SCK = 16;
  localparam int unsigned PCPA_PIN_S1MISO = 17;
  localparam int unsigned PCPA_PIN_S1MOSI = 18;
  localparam int unsigned PCPA_PIN_S1NSS = 19;
  localparam logic [23:0] PCPA_CAND = 24'h7fffff;
  localparam logic [23:0] PCPA_ONE = 24'h000001;

  ////////////////////////////////////////////////////////////////////////////
  // function indices in priority order
  localparam int unsigned PCPA_FN_TX = 0;
  localparam int unsigned PCPA_FN_RX = 1;
  localparam int unsigned PCPA_FN_S1SCK = 2;
  localparam int unsigned PCPA_FN_S1MISO = 3;
  localparam int unsigned PCPA_FN_S1MOSI = 4;
  localparam int unsigned PCPA_FN_S1NSS = 5;
  localparam int unsigned PCPA_FN_S0SCK = 6;
  localparam int unsigned PCPA_FN_S0NSS = 9;
  localparam int unsigned PCPA_FN_SDA = 10;
  localparam int unsigned PCPA_FN_SCL = 11;
  localparam int unsigned PCPA_FN_CHAN0 = 17;
  localparam int unsigned PCPA_FN_T1 = 25;

endpackage : pcpa_pkg

// >>> hdl/pcpa_sync.sv
// two-stage synchroniser for pad inputs
`timescale 1ns/100ps
module pcpa_sync #(
  parameter int unsigned WIDTH = 24
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule : pcpa_sync

// >>> hdl/pcpa_alloc.sv
// chained lowest-free-pin allocator for the floating functions
`timescale 1ns/100ps
module pcpa_alloc #(
  parameter int unsigned NPIN = 24,
  parameter int unsigned NFLT = 20
) (
  input wire logic [NPIN-1:0] free_i,
  input wire logic [NFLT-1:0] req_i,
  output logic [NFLT-1:0][NPIN-1:0] grant_o
);

  logic [NFLT:0][NPIN-1:0] free_w;
  localparam logic [NPIN-1:0] ONE = {{(NPIN-1){1'b0}}, 1'b1};

  assign free_w[0] = free_i;

  generate
    for (genvar k = 0; k < NFLT; k++) begin : g_stage
      logic [NPIN-1:0] pick_w;
      // isolate lowest free pin, then remove it for later stages if this stage requests it
      assign pick_w = free_w[k] & (~free_w[k] + ONE); // R5
      assign grant_o[k] = req_i[k] ? pick_w : '0; // R5
      assign free_w[k+1] = free_w[k] & ~grant_o[k]; // R6
    end
  endgenerate

endmodule : pcpa_alloc

// >>> hdl/pcpa_top.sv
// priority crossbar pin assigner top level
// Operation
// R1 - each enabled peripheral signal gets its own pin in fixed priority order; signals left once the free candidate pins run out get none
// R2 - only pins 0.0 to 2.6 with skip bit clear are candidates
// R3 - serial port, when enabled, takes fixed pins 0.4 and 0.5
// R4 - second spi takes 2.0 to 2.2, and 2.3 in 4-wire mode
// R5 - other functions in priority order take lowest free unskipped pins
// R6 - skipped pins and pins held by fixed functions are passed over
// R7 - software sets crossbar enable before using pins as digital outputs
// R8 - all pad drivers stay off while crossbar enable is clear
// R9 - two-wire data and clock pins are forced to open-drain
// R10 - first spi mode bits pick 3 or 4 wire; select routed only 4-wire
// R11 - first spi select pin presence shifts all lower priority functions
// R12 - pinout depends only on selections, skip masks and spi modes
// R13 - port 0 skip mask 0x0c removes pins 2 and 3 from assignment
// R14 - software skips pins used for analog, gpio or dedicated functions
// R15 - software keeps skip bits clear on the fixed function pins
// R16 - selection a is eight rw bits resetting to zero with listed enables
// R17 - channel field n routes channels 0 to n-1, zero none, seven reserved
// R18 - two-wire bus enable claims one data pin and one clock pin
// R19 - floating order: first_spi_port, two-wire, comparators, sysclk, channels, timers
// R20 - assignment is recomputed combinationally on any setting change
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
module pcpa_top
  import pcpa_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [PCPA_AW-1:0] reg_addr_i,
  input wire logic [PCPA_DW-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [PCPA_DW-1:0] reg_rdata_o,
  input wire logic [1:0] first_spi_port_nss_mode_i,
  input wire logic [1:0] second_spi_port_nss_mode_i,
  input wire logic [PCPA_NFN-1:0] fn_out_i,
  input wire logic [PCPA_NFN-1:0] fn_oe_i,
  output logic [PCPA_NFN-1:0] fn_in_o,
  input wire logic [PCPA_NPIN-1:0] port_latch_i,
  input wire logic [PCPA_NPIN-1:0] pad_in_i,
  output logic [PCPA_NPIN-1:0] pad_out_o,
  output logic [PCPA_NPIN-1:0] pad_oe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] sel_a_r;
  logic [7:0] sel_b_r;
  logic [7:0] sel_c_r;
  logic [7:0] skip_r [0:2];
  logic [7:0] mode_r [0:2];
  logic [7:0] rdata_r;
  logic [PCPA_NPIN-1:0] pad_out_r;
  logic [PCPA_NPIN-1:0] pad_oe_r;
  logic [PCPA_NFN-1:0] fn_in_r;

  logic [PCPA_NPIN-1:0] pad_sync;
  logic [PCPA_NPIN-1:0] skip_all;
  logic [PCPA_NPIN-1:0] mode_all;
  logic [PCPA_NPIN-1:0] claim_all;
  logic [PCPA_NPIN-1:0] pad_out_nxt;
  logic [PCPA_NPIN-1:0] pad_oe_nxt;
  logic [PCPA_NFN-1:0] fn_in_nxt;
  logic [7:0] rdata_nxt;
  logic [7:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire wr_sel_a = reg_wr_i && (reg_addr_i == PCPA_OFS_SEL_A);
  wire wr_sel_b = reg_wr_i && (reg_addr_i == PCPA_OFS_SEL_B);
  wire wr_sel_c = reg_wr_i && (reg_addr_i == PCPA_OFS_SEL_C);
  wire [3:0] skip_idx = reg_addr_i - PCPA_OFS_SKIP0;
  wire [3:0] mode_idx = reg_addr_i - PCPA_OFS_MODE0;
  wire [3:0] claim_idx = reg_addr_i - PCPA_OFS_CLAIM0;
  wire wr_skip = reg_wr_i && (skip_idx < 4'h3);
  wire wr_mode = reg_wr_i && (mode_idx < 4'h3);

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sel_a_r <= PCPA_RST_SEL; // R16
      sel_b_r <= PCPA_RST_SEL;
      sel_c_r <= PCPA_RST_SEL;
    end else begin
      if (wr_sel_a) begin
        sel_a_r <= reg_wdata_i; // R16
      end
      if (wr_sel_b) begin
        sel_b_r <= reg_wdata_i & PCPA_MASK_SEL_B;
      end
      if (wr_sel_c) begin
        sel_c_r <= reg_wdata_i & PCPA_MASK_SEL_C;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < 3; i++) begin
        skip_r[i] <= PCPA_RST_SKIP;
        mode_r[i] <= PCPA_RST_MODE;
      end
    end else begin
      if (wr_skip) begin
        skip_r[skip_idx[1:0]] <= reg_wdata_i;
      end
      if (wr_mode) begin
        mode_r[mode_idx[1:0]] <= reg_wdata_i;
      end
    end
  end

  assign skip_all = {skip_r[2], skip_r[1], skip_r[0]};
  assign mode_all = {mode_r[2], mode_r[1], mode_r[0]};

  // unmapped offsets read as zero
  assign rd_mux = (reg_addr_i == PCPA_OFS_SEL_A) ? sel_a_r :
                  (reg_addr_i == PCPA_OFS_SEL_B) ? sel_b_r :
                  (reg_addr_i == PCPA_OFS_SEL_C) ? sel_c_r :
                  (skip_idx < 4'h3) ? skip_r[skip_idx[1:0]] :
                  (mode_idx < 4'h3) ? mode_r[mode_idx[1:0]] :
                  (claim_idx < 4'h3) ? claim_all[claim_idx[1:0]*8 +: 8] :
                  8'h00;
  assign rdata_nxt = reg_rd_i ? rd_mux : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // requests
  wire xbe = sel_c_r[PCPA_C_XBE];
  wire serial_en = sel_a_r[PCPA_A_SERIAL];
  wire first_spi_port_en = sel_a_r[PCPA_A_FIRST_SPI_PORT];
  wire twb_en = sel_a_r[PCPA_A_TWB];
  wire second_spi_port_en = sel_b_r[PCPA_B_SECOND_SPI_PORT];
  wire [2:0] chan_en = sel_b_r[PCPA_B_CHAN_LSB +: 3];
  wire first_spi_port_4w = first_spi_port_nss_mode_i != PCPA_NSS_3WIRE; // R10
  wire second_spi_port_4w = second_spi_port_nss_mode_i != PCPA_NSS_3WIRE; // R4
  logic [5:0] chan_req;
  logic [PCPA_NFLT-1:0] flt_req;

  generate
    for (genvar c = 0; c < 6; c++) begin : g_chan
      assign chan_req[c] = (chan_en != PCPA_CHAN_RSVD) &&
                           (chan_en > 3'(c)); // R17
    end
  endgenerate

  // floating functions in priority order
  assign flt_req = {
    sel_b_r[PCPA_B_TMR1],
    sel_b_r[PCPA_B_TMR0],
    sel_b_r[PCPA_B_EXTCNT],
    chan_req,
    sel_a_r[PCPA_A_SYSCLK],
    sel_a_r[PCPA_A_CMP1A],
    sel_a_r[PCPA_A_CMP1],
    sel_a_r[PCPA_A_CMP0A],
    sel_a_r[PCPA_A_CMP0],
    twb_en,
    twb_en,
    first_spi_port_en && first_spi_port_4w,
    first_spi_port_en,
    first_spi_port_en,
    first_spi_port_en
  }; // R19 R18 R11

  ////////////////////////////////////////////////////////////////////////////
  // pin assignment
  logic [PCPA_NFN-1:0][PCPA_NPIN-1:0] grant;
  logic [PCPA_NFLT-1:0][PCPA_NPIN-1:0] flt_grant;
  logic [PCPA_NPIN-1:0] fixed_mask;
  logic [PCPA_NPIN-1:0] free_init;

  assign grant[PCPA_FN_TX] = serial_en ? (PCPA_ONE << PCPA_PIN_TX) : '0; // R3
  assign grant[PCPA_FN_RX] = serial_en ? (PCPA_ONE << PCPA_PIN_RX) : '0; // R3
  assign grant[PCPA_FN_S1SCK] =
    second_spi_port_en ? (PCPA_ONE << PCPA_PIN_S1SCK) : '0; // R4
  assign grant[PCPA_FN_S1MISO] =
    second_spi_port_en ? (PCPA_ONE << PCPA_PIN_S1MISO) : '0; // R4
  assign grant[PCPA_FN_S1MOSI] =
    second_spi_port_en ? (PCPA_ONE << PCPA_PIN_S1MOSI) : '0; // R4
  assign grant[PCPA_FN_S1NSS] =
    (second_spi_port_en && second_spi_port_4w) ? (PCPA_ONE << PCPA_PIN_S1NSS) : '0; // R4

  assign fixed_mask = grant[0] | grant[1] | grant[2] | grant[3] |
                      grant[4] | grant[5];
  // candidates: range limit, skip mask and fixed claims
  assign free_init = PCPA_CAND & ~skip_all & ~fixed_mask; // R2 R6 R13

  pcpa_alloc #(
    .NPIN(PCPA_NPIN),
    .NFLT(PCPA_NFLT)
  ) u_alloc (
    .free_i(free_init),
    .req_i(flt_req),
    .grant_o(flt_grant)
  ); // R1 R20 R12

  assign grant[PCPA_NFN-1:PCPA_NFIX] = flt_grant;

  ////////////////////////////////////////////////////////////////////////////
  // pad drive
  pcpa_sync #(
    .WIDTH(PCPA_NPIN)
  ) u_sync (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .async_i(pad_in_i),
    .sync_o(pad_sync)
  );

  generate
    for (genvar p = 0; p < PCPA_NPIN; p++) begin : g_pin
      logic [PCPA_NFN-1:0] col;
      for (genvar f = 0; f < PCPA_NFN; f++) begin : g_col
        assign col[f] = grant[f][p];
      end
      wire owned = |col;
      wire val = owned ? |(col & fn_out_i) : port_latch_i[p];
      wire dir = owned ? |(col & fn_oe_i) : 1'b1;
      wire twb_pin = col[PCPA_FN_SDA] | col[PCPA_FN_SCL];
      wire push = mode_all[p] && !twb_pin; // R9
      assign claim_all[p] = owned;
      assign pad_out_nxt[p] = val;
      assign pad_oe_nxt[p] = xbe && dir && (push || !val); // R8 R9
    end
    for (genvar f = 0; f < PCPA_NFN; f++) begin : g_fin
      assign fn_in_nxt[f] = |(grant[f] & pad_sync);
    end
  endgenerate

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pad_out_r <= '0;
      pad_oe_r <= '0;
      fn_in_r <= '0;
      rdata_r <= 8'h00;
    end else begin
      pad_out_r <= pad_out_nxt;
      pad_oe_r <= pad_oe_nxt;
      fn_in_r <= fn_in_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign pad_out_o = pad_out_r;
  assign pad_oe_o = pad_oe_r;
  assign fn_in_o = fn_in_r;
  assign reg_rdata_o = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [PCPA_NPIN-1:0] clash_w;
  logic [PCPA_NPIN-1:0] flt_mask;
  logic [PCPA_NPIN-1:0] twb_pins;
  logic [2:0] chan_cnt;

  generate
    for (genvar p = 0; p < PCPA_NPIN; p++) begin : g_chk
      assign clash_w[p] = !$onehot0(g_pin[p].col);
    end
  endgenerate

  always_comb begin
    flt_mask = '0;
    for (int k = 0; k < PCPA_NFLT; k++) begin
      flt_mask = flt_mask | flt_grant[k];
    end
  end

  assign twb_pins = grant[PCPA_FN_SDA] | grant[PCPA_FN_SCL];
  assign chan_cnt = 3'($countones(flt_req[PCPA_FN_CHAN0-PCPA_NFIX +: 6]));

  one_owner_a: assert property ( // R1
    @(posedge mclk_i) disable iff (!resetn_i) clash_w == '0)
    else $error("pin claimed by two functions");

  skip_honor_a: assert property ( // R2
    @(posedge mclk_i) disable iff (!resetn_i)
    (flt_mask & (skip_all | fixed_mask | ~PCPA_CAND)) == '0)
    else $error("floating function on skipped or fixed pin");

  serial_fixed_a: assert property ( // R3
    @(posedge mclk_i) disable iff (!resetn_i)
    serial_en |-> grant[PCPA_FN_TX] == 24'h000010 &&
                  grant[PCPA_FN_RX] == 24'h000020)
    else $error("serial port not on fixed pins");

  second_spi_port_fixed_a: assert property ( // R4
    @(posedge mclk_i) disable iff (!resetn_i)
    second_spi_port_en |-> (fixed_mask & 24'hff0000) ==
                (second_spi_port_4w ? 24'h0f0000 : 24'h070000))
    else $error("second spi pins wrong");

  lowest_free_a: assert property ( // R5
    @(posedge mclk_i) disable iff (!resetn_i)
    (first_spi_port_en && free_init != '0) |->
    grant[PCPA_FN_S0SCK] == (free_init & (~free_init + PCPA_ONE)))
    else $error("first floating function not on lowest free pin");

  drivers_off_a: assert property ( // R8
    @(posedge mclk_i) disable iff (!resetn_i)
    !xbe |=> pad_oe_o == '0)
    else $error("pad driven while crossbar disabled");

  twb_open_a: assert property ( // R9
    @(posedge mclk_i) disable iff (!resetn_i)
    (xbe && twb_en) |=> (pad_oe_o & pad_out_o & $past(twb_pins)) == '0)
    else $error("two-wire pin driven high");

  nss_route_a: assert property ( // R10
    @(posedge mclk_i) disable iff (!resetn_i)
    !first_spi_port_4w |-> grant[PCPA_FN_S0NSS] == '0)
    else $error("select routed in 3-wire mode");

  chan_count_a: assert property ( // R17
    @(posedge mclk_i) disable iff (!resetn_i)
    chan_cnt == ((chan_en == PCPA_CHAN_RSVD) ? 3'h0 : chan_en))
    else $error("channel request count wrong");

  sel_read_a: assert property ( // R16
    @(posedge mclk_i) disable iff (!resetn_i)
    (reg_rd_i && reg_addr_i == PCPA_OFS_SEL_A) |=>
    reg_rdata_o == $past(sel_a_r))
    else $error("selection a readback wrong");

endmodule : pcpa_top

// >>> test/pcpa_pad_model.sv
// pad model: driven pads show the driver, others the outside world
`timescale 1ns/100ps
module pcpa_pad_model (
  input wire logic [23:0] pad_out_i,
  input wire logic [23:0] pad_oe_i,
  input wire logic [23:0] ext_val_i,
  input wire logic ext_en_i,
  output logic [23:0] pad_in_o
);
  // an undriven pad with no outside driver floats high on its weak pull-up
  assign pad_in_o = (pad_oe_i & pad_out_i) |
                    (~pad_oe_i & (ext_en_i ? ext_val_i : 24'hffffff));
endmodule : pcpa_pad_model

// >>> test/pcpa_top_tb.sv
// self-checking bench for the priority crossbar pin assigner
`timescale 1ns/100ps
module pcpa_top_tb import pcpa_pkg::*; ();
  logic mclk_i, resetn_i, wr_s, rd_s;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  logic [1:0] m0, m1;
  logic [25:0] fn_out, fn_oe, fn_in;
  logic [23:0] latch, pad_in, pad_out, pad_oe, ext_val, own;
  int fails, tests_run;
  int pin_of [26];

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  pcpa_top u_pcpa_top (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_s),
    .reg_rd_i(rd_s), .reg_rdata_o(rdata), .first_spi_port_nss_mode_i(m0),
    .second_spi_port_nss_mode_i(m1), .fn_out_i(fn_out), .fn_oe_i(fn_oe),
    .fn_in_o(fn_in), .port_latch_i(latch), .pad_in_i(pad_in),
    .pad_out_o(pad_out), .pad_oe_o(pad_oe));
  pcpa_pad_model u_pcpa_pad_model (.pad_out_i(pad_out), .pad_oe_i(pad_oe),
    .ext_val_i(ext_val), .ext_en_i(1'b1), .pad_in_o(pad_in));

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge mclk_i);
    wr_s <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk_i);
    rd_s <= 1'b0;
    @(negedge mclk_i);
    chk(24'(rdata), 24'(exp));
  endtask : rchk

  task automatic settle(input int n);
    repeat (n) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask : settle

  // expected owner of every function and the claimed pin set
  task automatic calc(input logic [7:0] a, input logic [7:0] b,
      input logic [23:0] s, input logic [1:0] n0, input logic [1:0] n1);
    logic [25:0] en;
    int p;
    en = {b[5], b[4], b[3], 6'h00, a[3], a[7], a[6], a[5], a[4], a[2], a[2],
          a[1] && n0 != 2'h0, {3{a[1]}}, b[6] && n1 != 2'h0, {3{b[6]}},
          a[0], a[0]};
    for (int k = 0; k < 6; k++) en[17+k] = b[2:0] != 3'h7 && k < int'(b[2:0]);
    own = '0;
    for (int f = 0; f < 26; f++) begin
      pin_of[f] = -1;
      if (en[f] && f < 6) begin
        pin_of[f] = (f < 2) ? 4 + f : 14 + f;
        own[pin_of[f]] = 1'b1;
      end
    end
    for (int f = 6; f < 26; f++) begin
      p = 0;
      while (p < 23 && (s[p] || own[p])) p++;
      if (en[f] && p < 23) begin
        pin_of[f] = p;
        own[p] = 1'b1;
      end
    end
  endtask : calc

  task automatic cfg(input logic [7:0] a, input logic [7:0] b,
      input logic [23:0] s, input logic [1:0] n0, input logic [1:0] n1);
    calc(a, b, s, n0, n1);
    wr(PCPA_OFS_SEL_A, a);
    wr(PCPA_OFS_SEL_B, b);
    wr(PCPA_OFS_SKIP0, s[7:0]);
    wr(4'h4, s[15:8]);
    wr(4'h5, s[23:16]);
    @(posedge mclk_i);
    m0 <= n0;
    m1 <= n1;
    fn_oe <= '1;
    fn_out <= '0;
    settle(3);
    chk(pad_oe, own);
    rchk(PCPA_OFS_CLAIM0, own[7:0]);
    rchk(4'ha, own[15:8]);
    rchk(4'hb, own[23:16]);
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk_i);
      fn_oe <= '0;
      ext_val <= (i == 0) ? 24'h5a3c1e : 24'ha5c3e1;
      settle(5);
      for (int f = 0; f < 26; f++)
        chk(24'(fn_in[f]), 24'(pin_of[f] < 0 ? 1'b0 : ext_val[pin_of[f]]));
    end
  endtask : cfg

  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    @(negedge mclk_i);
    chk(pad_oe, 24'h000000);
    for (int i = 0; i < 12; i++) rchk(4'(i), 8'h00);
  endtask : t_reset

  task automatic t_regs();
    wr(PCPA_OFS_SEL_A, 8'hff);
    rchk(PCPA_OFS_SEL_A, 8'hff);
    wr(PCPA_OFS_SEL_B, 8'hff);
    rchk(PCPA_OFS_SEL_B, PCPA_MASK_SEL_B);
    wr(4'hf, 8'hff);
    rchk(4'hf, 8'h00);
    wr(PCPA_OFS_SEL_B, 8'h00);
  endtask : t_regs

  // drivers off without crossbar enable, two-wire pins open-drain with it
  task automatic t_drive();
    calc(8'hff, 8'h00, 24'h0, 2'h0, 2'h0);
    for (int i = 6; i < 9; i++) wr(4'(i), 8'hff);
    @(posedge mclk_i);
    fn_oe <= '1;
    fn_out <= '1;
    latch <= '0;
    settle(3);
    chk(pad_oe, 24'h000000);
    wr(PCPA_OFS_SEL_C, 8'hff);
    rchk(PCPA_OFS_SEL_C, PCPA_MASK_SEL_C);
    settle(2);
    chk(pad_oe, ~((24'h1 << pin_of[10]) | (24'h1 << pin_of[11])));
    chk(pad_out, own);
    for (int i = 6; i < 9; i++) wr(4'(i), 8'h00);
    @(posedge mclk_i);
    latch <= '1;
  endtask : t_drive

  task automatic t_map();
    cfg(8'h01, 8'h00, 24'h0, 2'h0, 2'h0);
    cfg(8'h00, 8'h40, 24'h0, 2'h0, 2'h0);
    cfg(8'h00, 8'h40, 24'h0, 2'h0, 2'h1);
    cfg(8'h07, 8'h00, 24'h0, 2'h0, 2'h0);
    cfg(8'h07, 8'h00, 24'h0, 2'h3, 2'h0);
    cfg(8'h3d, 8'h00, 24'h00000c, 2'h0, 2'h0);
    cfg(8'hff, 8'h7e, 24'h400000, 2'h2, 2'h1);
    cfg(8'hf8, 8'h38, 24'h0, 2'h0, 2'h0);
    for (int k = 0; k < 8; k++) cfg(8'h04, 8'(k), 24'h0, 2'h0, 2'h0);
  endtask : t_map

  // a change of the mode inputs alone reaches the pads one cycle later
  task automatic t_comb();
    wr(PCPA_OFS_SEL_A, 8'h06);
    wr(PCPA_OFS_SEL_B, 8'h00);
    calc(8'h06, 8'h00, 24'h0, 2'h0, 2'h0);
    @(posedge mclk_i);
    m0 <= 2'h0;
    fn_oe <= '1;
    settle(2);
    chk(pad_oe, own);
    calc(8'h06, 8'h00, 24'h0, 2'h1, 2'h0);
    @(posedge mclk_i);
    m0 <= 2'h1;
    settle(1);
    chk(pad_oe, own);
  endtask : t_comb

  //////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    resetn_i = 1'b0;
    {wr_s, rd_s, addr, wdata, m0, m1} = '0;
    {fn_out, fn_oe} = '0;
    latch = '1;
    ext_val = '0;
    fails = 0;
    tests_run = 0;
    repeat (5) @(posedge mclk_i);
    resetn_i <= 1'b1;
    t_reset();
    t_regs();
    t_drive();
    t_map();
    t_comb();
    report_and_stop();
  end

  initial begin
    repeat (100000) @(posedge mclk_i);
    fails++;
    report_and_stop();
  end
endmodule : pcpa_top_tb
